/* core/csalo_pkg.sv */
// Purpose: Constants for cursor advance and layer overlay control
// Assumes: Host register port with byte data and 16-bit address
// Notes:   All offsets, fields and command codes live here
package csalo_pkg;
    localparam logic [15:0] ADDR_DIR      = 16'h8017;
    localparam logic [15:0] ADDR_OVL      = 16'h8018;
    localparam logic [7:0]  DIR_RESET     = 8'h00;
    localparam logic [7:0]  OVL_RESET     = 8'h00;
    localparam logic [7:0]  CMD_DIR_RIGHT = 8'h4c;
    localparam logic [7:0]  CMD_DIR_LEFT  = 8'h4d;
    localparam logic [7:0]  CMD_DIR_UP    = 8'h4e;
    localparam logic [7:0]  CMD_DIR_DOWN  = 8'h4f;
    localparam logic [7:0]  CMD_OVERLAY   = 8'h5b;
    localparam int          OVL_THREE_BIT = 4;
    localparam int          OVL_BLK3_BIT  = 3;
    localparam int          OVL_BLK1_BIT  = 2;
    localparam logic [1:0]  DIR_RIGHT     = 2'h0;
    localparam logic [1:0]  DIR_LEFT      = 2'h1;
    localparam logic [1:0]  DIR_UP        = 2'h2;
    localparam logic [1:0]  DIR_DOWN      = 2'h3;
    localparam logic [1:0]  MIX_OR        = 2'h0;
    localparam logic [1:0]  MIX_XOR       = 2'h1;
    localparam logic [1:0]  MIX_AND       = 2'h2;
    localparam logic [1:0]  MIX_RESERVED  = 2'h3;
    localparam logic [7:0]  DIR_MASK      = 8'h03;
    localparam logic [7:0]  OVL_MASK      = 8'h1f;
endpackage : csalo_pkg

/* core/csalo_core.sv */
// Purpose: Cursor advance direction and layer overlay composition
// Assumes: Host port already on mclk; pixels arrive on mclk
// Notes:   One packed state struct, registered once per cycle
`timescale 1ns/100ps
// Overview of operation
// - Each display memory read or write advances cursor address in set direction.
// - Left/right moves one address; up/down moves by horizontal pitch.
// - Direction field: 0 right, 1 left, 2 up, 3 down.
// - Indirect commands 4C to 4F carry direction in the code.
// - Overlay bit 4 selects two layers at 0, three at 1.
// - Overlay bit 3 sets block 3 text at 0, graphics at 1.
// - Overlay bit 2 sets block 1 text at 0, graphics at 1.
// - Blocks 2 and 4 always render as graphics.
// - Method 0 outputs OR of all three layers.
// - Method 1 outputs first XOR second, ORed with third.
// - Method 2 outputs first AND second, ORed with third; 3 reserved.
// - One composition method applies per layer across split blocks.
// - Indirect overlay command parameter loads the overlay register.
// - First layer text or graphics; text first layer disables third.
module csalo_core #(
    parameter int PITCH_W = 16
) (
    input  wire logic               mclk,
    input  wire logic               nrst,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [15:0]        reg_addr,
    input  wire logic [7:0]         reg_wdata,
    output logic      [7:0]         reg_rdata,
    input  wire logic               cmd_wr,
    input  wire logic [7:0]         cmd_code,
    input  wire logic               param_wr,
    input  wire logic [7:0]         param_data,
    input  wire logic               cursor_load,
    input  wire logic [15:0]        cursor_load_val,
    input  wire logic               mem_access,
    input  wire logic [PITCH_W-1:0] addr_pitch,
    output logic      [15:0]        cursor_addr,
    input  wire logic [1:0]         screen_block,
    input  wire logic               first_layer,
    input  wire logic               second_layer,
    input  wire logic               third_layer,
    output logic                    pixel_out,
    output logic                    block_graphics,
    output logic                    three_layer_select,
    output logic                    third_layer_active
);
    typedef struct packed {
        logic [7:0]  dir;
        logic [7:0]  ovl;
        logic        ovl_pend;
        logic [15:0] cur;
        logic        pix;
        logic        gfx;
        logic [7:0]  rdata;
    } csalo_state_t;

    csalo_state_t st_q;
    csalo_state_t st_d;
    logic         rst_n;
    logic         sync_q1;
    logic         sync_q2;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync_q1 <= 1'b0;
            sync_q2 <= 1'b0;
        end else begin
            sync_q1 <= 1'b1;
            sync_q2 <= sync_q1;
        end
    end
    assign rst_n = sync_q2;

    function automatic logic compose(input logic [1:0] m, input logic a, input logic b, input logic c);
        unique case (m)
            csalo_pkg::MIX_OR:  compose = a | b | c;
            csalo_pkg::MIX_XOR: compose = (a ^ b) | c;
            csalo_pkg::MIX_AND: compose = (a & b) | c;
            default:            compose = 1'b0;
        endcase
    endfunction : compose

    function automatic logic reg_hit(input logic stb, input logic [15:0] a, input logic [15:0] t);
        reg_hit = stb && (a == t);
    endfunction : reg_hit

    logic       l3_use;
    logic [1:0] mix;

    always_comb begin
        st_d = st_q;
        mix  = st_q.ovl[1:0];
        if (reg_hit(reg_wr, reg_addr, csalo_pkg::ADDR_DIR))
            st_d.dir = reg_wdata & csalo_pkg::DIR_MASK;
        if (reg_hit(reg_wr, reg_addr, csalo_pkg::ADDR_OVL))
            st_d.ovl = reg_wdata & csalo_pkg::OVL_MASK;
        if (cmd_wr) begin
            st_d.ovl_pend = (cmd_code == csalo_pkg::CMD_OVERLAY);
            if (cmd_code[7:2] == csalo_pkg::CMD_DIR_RIGHT[7:2])
                st_d.dir = {6'h00, cmd_code[1:0]};
        end else if (param_wr && st_q.ovl_pend) begin
            st_d.ovl      = param_data & csalo_pkg::OVL_MASK;
            st_d.ovl_pend = 1'b0;
        end
        if (cursor_load)
            st_d.cur = cursor_load_val;
        else if (mem_access) begin
            unique case (st_q.dir[1:0])
                csalo_pkg::DIR_RIGHT: st_d.cur = st_q.cur + 16'h0001;
                csalo_pkg::DIR_LEFT:  st_d.cur = st_q.cur - 16'h0001;
                csalo_pkg::DIR_UP:    st_d.cur = st_q.cur - 16'(addr_pitch);
                csalo_pkg::DIR_DOWN:  st_d.cur = st_q.cur + 16'(addr_pitch);
            endcase
        end
        unique case (screen_block)
            2'h0:    st_d.gfx = st_q.ovl[csalo_pkg::OVL_BLK1_BIT];
            2'h2:    st_d.gfx = st_q.ovl[csalo_pkg::OVL_BLK3_BIT];
            default: st_d.gfx = 1'b1;
        endcase
        // Third layer only with three layers and a graphics first layer
        l3_use = st_q.ovl[csalo_pkg::OVL_THREE_BIT] & st_q.ovl[csalo_pkg::OVL_BLK1_BIT];
        st_d.pix = compose(mix, first_layer, second_layer, third_layer & l3_use);
        if (reg_hit(reg_rd, reg_addr, csalo_pkg::ADDR_DIR))
            st_d.rdata = st_q.dir;
        else if (reg_hit(reg_rd, reg_addr, csalo_pkg::ADDR_OVL))
            st_d.rdata = st_q.ovl;
        else
            st_d.rdata = 8'h00;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q       <= '0;
            st_q.dir   <= csalo_pkg::DIR_RESET;
            st_q.ovl   <= csalo_pkg::OVL_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata          = st_q.rdata;
    assign cursor_addr        = st_q.cur;
    assign pixel_out          = st_q.pix;
    assign block_graphics     = st_q.gfx;
    assign three_layer_select = st_q.ovl[csalo_pkg::OVL_THREE_BIT];
    assign third_layer_active = st_q.ovl[csalo_pkg::OVL_THREE_BIT] & st_q.ovl[csalo_pkg::OVL_BLK1_BIT];

    // Cursor advance checks
    a_right_step: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_access && !cursor_load && st_q.dir[1:0] == 2'h0 |=> cursor_addr == $past(cursor_addr) + 16'h0001)
        else $error("Right advance wrong");
    a_left_step: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_access && !cursor_load && st_q.dir[1:0] == 2'h1 |=> cursor_addr == $past(cursor_addr) - 16'h0001)
        else $error("Left advance wrong");
    a_up_step: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_access && !cursor_load && st_q.dir[1:0] == 2'h2
        |=> cursor_addr == $past(cursor_addr) - 16'($past(addr_pitch)))
        else $error("Up advance wrong");
    a_down_step: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_access && !cursor_load && st_q.dir[1:0] == 2'h3
        |=> cursor_addr == $past(cursor_addr) + 16'($past(addr_pitch)))
        else $error("Down advance wrong");
    a_hold_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        !mem_access && !cursor_load |=> $stable(cursor_addr))
        else $error("Cursor moved without access");
    a_load_wins: assert property (@(posedge mclk) disable iff (!rst_n)
        cursor_load |=> cursor_addr == $past(cursor_load_val))
        else $error("Cursor load not taken");

    // Register and command checks
    a_dir_masked: assert property (@(posedge mclk) disable iff (!rst_n)
        reg_wr && reg_addr == csalo_pkg::ADDR_DIR && !cmd_wr
        |=> st_q.dir == ($past(reg_wdata) & csalo_pkg::DIR_MASK))
        else $error("Direction write wrong");
    a_cmd_right: assert property (@(posedge mclk) disable iff (!rst_n)
        cmd_wr && cmd_code == csalo_pkg::CMD_DIR_RIGHT |=> st_q.dir == 8'h00)
        else $error("Right command not taken");
    a_cmd_dir: assert property (@(posedge mclk) disable iff (!rst_n)
        cmd_wr && cmd_code == 8'h4e |=> st_q.dir == 8'h02)
        else $error("Up command not taken");
    a_cmd_down: assert property (@(posedge mclk) disable iff (!rst_n)
        cmd_wr && cmd_code == csalo_pkg::CMD_DIR_DOWN |=> st_q.dir == 8'h03)
        else $error("Down command not taken");
    a_ovl_param: assert property (@(posedge mclk) disable iff (!rst_n)
        st_q.ovl_pend && param_wr && !cmd_wr |=> st_q.ovl == ($past(param_data) & 8'h1f))
        else $error("Overlay parameter not taken");
    a_param_disarm: assert property (@(posedge mclk) disable iff (!rst_n)
        st_q.ovl_pend && param_wr && !cmd_wr |=> !st_q.ovl_pend)
        else $error("Overlay command still armed");
    a_read_dir: assert property (@(posedge mclk) disable iff (!rst_n)
        reg_rd && reg_addr == csalo_pkg::ADDR_DIR |=> reg_rdata == $past(st_q.dir))
        else $error("Direction read wrong");
    a_read_ovl: assert property (@(posedge mclk) disable iff (!rst_n)
        reg_rd && reg_addr == csalo_pkg::ADDR_OVL |=> reg_rdata == $past(st_q.ovl))
        else $error("Overlay read wrong");

    // Block mode and composition checks
    a_block_even: assert property (@(posedge mclk) disable iff (!rst_n)
        screen_block[0] |=> block_graphics)
        else $error("Blocks 2 and 4 not graphics");
    a_block_one: assert property (@(posedge mclk) disable iff (!rst_n)
        screen_block == 2'h0 |=> block_graphics == $past(st_q.ovl[2]))
        else $error("Block 1 mode wrong");
    a_block_three: assert property (@(posedge mclk) disable iff (!rst_n)
        screen_block == 2'h2 |=> block_graphics == $past(st_q.ovl[3]))
        else $error("Block 3 mode wrong");
    a_mix_xor: assert property (@(posedge mclk) disable iff (!rst_n)
        st_q.ovl[1:0] == 2'h1 && !third_layer |=> pixel_out == ($past(first_layer) ^ $past(second_layer)))
        else $error("XOR composition wrong");
    a_mix_and: assert property (@(posedge mclk) disable iff (!rst_n)
        st_q.ovl[1:0] == 2'h2 && !third_layer |=> pixel_out == ($past(first_layer) & $past(second_layer)))
        else $error("AND composition wrong");
    a_mix_or: assert property (@(posedge mclk) disable iff (!rst_n)
        st_q.ovl[1:0] == 2'h0 && first_layer |=> pixel_out)
        else $error("OR composition wrong");
    a_third_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        !third_layer_active && st_q.ovl[1:0] == 2'h0 && !first_layer && !second_layer
        |=> !pixel_out)
        else $error("Third layer not suppressed");
    a_third_pass: assert property (@(posedge mclk) disable iff (!rst_n)
        third_layer_active && third_layer && st_q.ovl[1:0] != 2'h3 |=> pixel_out)
        else $error("Third layer not shown");

    // Reset check
    a_reset_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(rst_n) |-> st_q.dir == csalo_pkg::DIR_RESET && st_q.ovl == csalo_pkg::OVL_RESET)
        else $error("Registers not cleared by reset");
endmodule : csalo_core

/* sim/csalo_host.sv */
// Purpose: Host CPU model issuing register, command and parameter strobes
// Assumes: One-cycle strobes launched 2 ns after mclk rises
// Notes:   Released data lines show the inverse of their last value
`timescale 1ns/100ps
module csalo_host (
    input  wire logic        mclk,
    input  wire logic [7:0]  reg_rdata,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic             cmd_wr,
    output logic             param_wr,
    output logic      [15:0] reg_addr,
    output logic      [7:0]  reg_wdata,
    output logic      [7:0]  cmd_code,
    output logic      [7:0]  param_data
);
    initial begin
        {reg_wr, reg_rd, cmd_wr, param_wr, reg_addr, reg_wdata, cmd_code, param_data} = '0;
    end
    // Kind 0 write, 1 read, 2 command, 3 parameter
    task automatic op(input int k, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk) #2;
        reg_addr   = a;
        reg_wdata  = d;
        cmd_code   = d;
        param_data = d;
        reg_wr     = (k == 0);
        reg_rd     = (k == 1);
        cmd_wr     = (k == 2);
        param_wr   = (k == 3);
        @(posedge mclk) #2;
        q = reg_rdata;
        {reg_wr, reg_rd, cmd_wr, param_wr} = 4'h0;
        reg_addr   = ~a;
        {reg_wdata, cmd_code, param_data} = {3{~d}};
    endtask : op
endmodule : csalo_host

/* sim/test_cursor_shift_and_layer_overlay.sv */
// Purpose: Self-checking bench for cursor advance and layer overlay
// Assumes: Host model owns register strobes; bench drives cursor and pixels
// Notes:   Integer reference model compared at every result
`timescale 1ns/100ps
module test_cursor_shift_and_layer_overlay;
    logic        mclk, nrst, reg_wr, reg_rd, cmd_wr, param_wr, cursor_load, mem_access;
    logic [15:0] reg_addr, cursor_load_val, addr_pitch, cursor_addr;
    logic [7:0]  reg_wdata, reg_rdata, cmd_code, param_data, q, ov, dv;
    logic [1:0]  screen_block;
    logic        first_layer, second_layer, third_layer, pixel_out, block_graphics, three_layer_select;
    logic        third_layer_active;
    int          n_errors = 0, cmp_count = 0, seed = 32'ha657, cur, dir;
    always #25 mclk = ~mclk;
    csalo_core u_dut (.mclk(mclk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmd_wr(cmd_wr), .cmd_code(cmd_code), .param_wr(param_wr),
        .param_data(param_data), .cursor_load(cursor_load), .cursor_load_val(cursor_load_val),
        .mem_access(mem_access), .addr_pitch(addr_pitch), .cursor_addr(cursor_addr), .screen_block(screen_block),
        .first_layer(first_layer), .second_layer(second_layer), .third_layer(third_layer), .pixel_out(pixel_out),
        .block_graphics(block_graphics), .three_layer_select(three_layer_select),
        .third_layer_active(third_layer_active));
    csalo_host u_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .cmd_wr(cmd_wr),
        .param_wr(param_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .cmd_code(cmd_code),
        .param_data(param_data));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("Errors %0d, compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic px;
        logic c, x;
        @(posedge mclk) #2;
        {screen_block, first_layer, second_layer, third_layer} = 5'($random(seed));
        c = third_layer & ov[4] & ov[2];
        x = (ov[1:0] == 2'h0) ? (first_layer | second_layer | c) :
            (ov[1:0] == 2'h1) ? ((first_layer ^ second_layer) | c) : ((first_layer & second_layer) | c);
        @(posedge mclk) #2;
        chk(pixel_out, 16'(x));
        chk(block_graphics, screen_block[0] | (screen_block[1] ? ov[3] : ov[2]));
        chk({three_layer_select, third_layer_active}, {ov[4], ov[4] & ov[2]});
    endtask : px
    task automatic mv;
        @(posedge mclk) #2;
        mem_access = 1'b1;
        @(posedge mclk) #2;
        mem_access = 1'b0;
        cur = (dir == 0) ? cur + 1 : (dir == 1) ? cur - 1 : (dir == 2) ? cur - addr_pitch : cur + addr_pitch;
        chk(cursor_addr, cur[15:0]);
    endtask : mv
    initial begin
        {mclk, nrst, cursor_load, mem_access, screen_block, first_layer, second_layer, third_layer} = '0;
        {cursor_load_val, addr_pitch, ov} = '0;
        repeat (6) @(posedge mclk);
        #2 nrst = 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 3; i++) begin
            u_host.op(1, 16'h8017 + 16'(i), 8'h00, q);
            chk(q, 16'h0000);
        end
        for (int m = 0; m < 8; m++) begin
            dir = m % 4;
            addr_pitch = 16'($random(seed));
            dv = 8'($random(seed));
            dv[1:0] = dir[1:0];
            if (m < 4) begin
                u_host.op(0, csalo_pkg::ADDR_DIR, dv, q);
            end else begin
                u_host.op(2, 16'h0000, csalo_pkg::CMD_DIR_RIGHT + 8'(dir), q);
            end
            u_host.op(1, csalo_pkg::ADDR_DIR, 8'h00, q);
            chk(q, 16'(dir));
            @(posedge mclk) #2;
            cursor_load = 1'b1;
            cursor_load_val = 16'($random(seed));
            @(posedge mclk) #2;
            cursor_load = 1'b0;
            cur = cursor_load_val;
            repeat (3) mv;
        end
        for (int m = 0; m < 12; m++) begin
            ov = 8'($random(seed));
            ov[1:0] = 2'(m % 3);
            if (m > 8) begin
                ov[4:2] = 3'h7;
            end
            if (!(ov[2] && ov[3])) begin
                ov[4] = 1'b0;
            end
            if (m % 2 == 1) begin
                u_host.op(2, 16'h0000, csalo_pkg::CMD_OVERLAY, q);
                u_host.op(3, 16'h0000, ov, q);
            end else begin
                u_host.op(0, csalo_pkg::ADDR_OVL, ov, q);
            end
            u_host.op(1, csalo_pkg::ADDR_OVL, 8'h00, q);
            chk(q, 16'(ov & csalo_pkg::OVL_MASK));
            repeat (8) px;
        end
        report_and_stop;
    end
    initial begin
        #(4000 * 50);
        n_errors++;
        report_and_stop;
    end
endmodule : test_cursor_shift_and_layer_overlay
